// >>> pdwd_pkg.sv
// package: register map, field layout, reset values and timing constants for the power-down watchdog
package pdwd_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] PDWD_OFF_WDT_CTRL = 8'h00;
    localparam logic [7:0] PDWD_OFF_RST_FLAGS = 8'h04;
    localparam logic [7:0] PDWD_OFF_CLK_CTRL = 8'h08;
    localparam logic [7:0] PDWD_OFF_WAKE_EN = 8'h0C;
    localparam logic [7:0] PDWD_OFF_STATUS = 8'h10;
    // watchdog control field positions
    localparam int PDWD_KEY_LSB = 3;
    localparam int PDWD_KEY_MSB = 7;
    localparam int PDWD_SEL_MSB = 2;
    // reset flag register bit positions
    localparam int PDWD_RF_WDT = 0;
    localparam int PDWD_RF_LVR = 2;
    localparam int PDWD_RF_RCTL = 3;
    // clock control bit positions
    localparam int PDWD_CC_LOW_IDLE = 0;
    localparam int PDWD_CC_HIGH_IDLE = 1;
    // key codes and reset values
    localparam logic [4:0] PDWD_KEY_DISABLE = 5'h15;
    localparam logic [4:0] PDWD_KEY_ENABLE = 5'h0A;
    localparam logic [7:0] PDWD_WDT_CTRL_RST = 8'h53;
    localparam logic [7:0] PDWD_CLK_CTRL_RST = 8'h00;
    localparam logic [7:0] PDWD_WAKE_EN_RST = 8'h00;
    // timing: system clock rate and software reset delay
    localparam int PDWD_CLK_HZ = 200_000_000;
    localparam int PDWD_SRESET_NS = 100_000;
    localparam int PDWD_SRESET_CYC = (PDWD_SRESET_NS / 1000) * (PDWD_CLK_HZ / 1_000_000);
    localparam int PDWD_RC_HZ = 32_000;
    localparam int PDWD_RC_DIV = PDWD_CLK_HZ / PDWD_RC_HZ;
    // bus responses
    localparam logic [1:0] PDWD_RESP_OKAY = 2'h0;
    localparam logic [1:0] PDWD_RESP_SLVERR = 2'h2;
    // operating modes
    typedef enum logic [2:0] {
        PDWD_RUN,
        PDWD_SLEEP,
        PDWD_IDLE_ZERO,
        PDWD_IDLE_ONE,
        PDWD_IDLE_TWO
    } pdwd_mode_t;
endpackage

// >>> pdwd_power_down_watchdog.sv
// module: power-down mode control, wake-up logic and watchdog timer with axi4-lite registers
//
// Operation
// - halt with both idle enables low: sleep
// - high idle 0, low idle 1: idle zero
// - both idle enables high: idle one
// - high idle 1, low idle 0: idle two
// - power-down halts program, state kept
// - entry sets power-down flag, clears timeout
// - halt clears watchdog counter; runs if enabled
// - wake on port edge, reset, interrupt, watchdog
// - external reset wake does full reset
// - power-down flag cleared by power-up, clear
// - sleep overflow sets timeout, resets pc/sp
// - enabled port pin falling edge wakes, resumes
// - disabled or stack-full interrupt resumes, stays pending
// - enabled interrupt, free stack: normal response
// - flag set before entry never wakes
// - watchdog counts low-speed rc clock, divided
// - select picks 2^N, N 8..18 table
// - key 10101 disables; others but 01010 request reset
// - bad key: delay, then reset, set flag
// - key 01010 enables, value after power-on
// - normal timeout resets device, sets timeout
// - clear instruction or halt clears counter
// - reset flag set by hardware, cleared software
module pdwd_power_down_watchdog import pdwd_pkg::*; #(
    parameter int PORT_W = 8,
    parameter int INT_W = 8,
    parameter int SRESET_CYCLES = PDWD_SRESET_CYC,
    parameter int RC_DIVIDE = PDWD_RC_DIV
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // cpu side events
    input wire logic halt_exec,
    input wire logic wdt_clear_exec,
    input wire logic ext_reset,
    input wire logic power_up,
    input wire logic lvr_event,
    input wire logic stack_full,
    input wire logic [INT_W-1:0] int_req,
    input wire logic [INT_W-1:0] int_enable,
    input wire logic [PORT_W-1:0] port_a_in,
    // outputs to core
    output logic cpu_stopped,
    output logic high_clock_on,
    output logic sub_clock_on,
    output logic rc_clock_on,
    output logic wake_pulse,
    output logic resume_next,
    output logic take_interrupt,
    output logic pc_sp_reset,
    output logic device_reset,
    output logic power_down_status_flag,
    output logic watchdog_timeout_flag,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // map select code to the divide exponent
    function automatic logic [4:0] sel_exp(input logic [2:0] sel);
        case (sel)
            3'h0: sel_exp = 5'h08;
            3'h1: sel_exp = 5'h0A;
            3'h2: sel_exp = 5'h0C;
            3'h3: sel_exp = 5'h0E;
            3'h4: sel_exp = 5'h0F;
            3'h5: sel_exp = 5'h10;
            3'h6: sel_exp = 5'h11;
            default: sel_exp = 5'h12;
        endcase
    endfunction

    // register state
    logic [7:0] wdt_ctrl_reg; // key and timeout select
    logic [7:0] clk_ctrl_reg; // idle enables
    logic [PORT_W-1:0] wake_en_reg; // per-pin wake enables
    logic wd_rst_flag_reg; // watchdog-control reset flag
    logic ctl_rst_flag_reg; // reset-control reset flag, held at zero here
    logic lv_rst_flag_reg; // low-voltage reset flag
    logic pd_flag_reg; // power-down status flag
    logic to_reg; // watchdog timeout flag
    pdwd_mode_t mode_reg; // current operating mode
    logic [PORT_W-1:0] port_prev_reg; // port history for edge detect
    logic [INT_W-1:0] int_mask_reg; // requests already set at entry
    logic [15:0] rc_div_reg; // system clock to rc rate divider
    logic [17:0] wdt_cnt_reg; // watchdog counter in rc ticks
    logic [31:0] sreset_cnt_reg; // pending software reset delay
    logic sreset_pend_reg; // bad key seen, waiting out delay

    // key decode
    wire [4:0] key = wdt_ctrl_reg[PDWD_KEY_MSB:PDWD_KEY_LSB];
    wire wdt_enabled = (key == PDWD_KEY_ENABLE);
    wire key_bad = !wdt_enabled && (key != PDWD_KEY_DISABLE);
    wire asleep = (mode_reg != PDWD_RUN);
    // rc tick enable: the rc clock runs whenever the watchdog is enabled
    wire rc_tick = (rc_div_reg == 16'(RC_DIVIDE - 1));
    wire [17:0] wdt_top = 18'((32'h1 << sel_exp(wdt_ctrl_reg[PDWD_SEL_MSB:0])) - 1);
    wire wdt_ovf = wdt_enabled && rc_tick && (wdt_cnt_reg == wdt_top);
    // wake sources
    wire [PORT_W-1:0] port_fall = port_prev_reg & ~port_a_in & wake_en_reg;
    wire [INT_W-1:0] int_wake = int_req & ~int_mask_reg;
    wire int_serv = |(int_wake & int_enable) && !stack_full;
    wire port_wake = asleep && |port_fall;
    wire irq_wake = asleep && |int_wake;
    wire sreset_fire = sreset_pend_reg && (sreset_cnt_reg == 32'(SRESET_CYCLES - 1));
    // mode selected by halt
    wire hi_idle = clk_ctrl_reg[PDWD_CC_HIGH_IDLE];
    wire lo_idle = clk_ctrl_reg[PDWD_CC_LOW_IDLE];
    pdwd_mode_t halt_mode;
    always_comb begin
        // idle-enable decode on halt
        case ({hi_idle, lo_idle})
            2'b00: halt_mode = PDWD_SLEEP;
            2'b01: halt_mode = PDWD_IDLE_ZERO;
            2'b11: halt_mode = PDWD_IDLE_ONE;
            default: halt_mode = PDWD_IDLE_TWO;
        endcase
    end
    wire enter = !asleep && halt_exec;
    wire any_wake = port_wake || irq_wake || (asleep && wdt_ovf);
    wire full_reset = ext_reset || power_up || sreset_fire || (!asleep && wdt_ovf);

    // mode sequencing: halt enters, any wake source returns to run
    always_ff @(posedge clock) begin
        if (rst || full_reset) begin
            mode_reg <= PDWD_RUN;
        end else if (enter) begin
            mode_reg <= halt_mode;
        end else if (any_wake) begin
            mode_reg <= PDWD_RUN;
        end
    end

    // snapshot pending requests at entry so they cannot wake
    always_ff @(posedge clock) begin
        if (rst) begin
            int_mask_reg <= '0;
        end else if (enter) begin
            int_mask_reg <= int_req;
        end else if (!asleep) begin
            int_mask_reg <= '0;
        end
    end

    // port history, sampled every cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            port_prev_reg <= '1;
        end else begin
            port_prev_reg <= port_a_in;
        end
    end

    // divider producing the rc-rate tick
    always_ff @(posedge clock) begin
        if (rst || !wdt_enabled || rc_tick) begin
            rc_div_reg <= '0;
        end else begin
            rc_div_reg <= rc_div_reg + 16'h1;
        end
    end

    // watchdog counter: clear on halt, clear instruction, overflow
    always_ff @(posedge clock) begin
        if (rst || full_reset || enter || wdt_clear_exec || !wdt_enabled) begin
            wdt_cnt_reg <= '0;
        end else if (wdt_ovf) begin
            wdt_cnt_reg <= '0;
        end else if (rc_tick) begin
            wdt_cnt_reg <= wdt_cnt_reg + 18'h1;
        end
    end

    // bad-key delay before the software reset
    always_ff @(posedge clock) begin
        if (rst || sreset_fire || !key_bad) begin
            sreset_pend_reg <= 1'b0;
            sreset_cnt_reg <= '0;
        end else begin
            sreset_pend_reg <= 1'b1;
            sreset_cnt_reg <= sreset_pend_reg ? sreset_cnt_reg + 32'h1 : '0;
        end
    end

    // status flags, kept apart so an overflow never blocks the clear of the power-down flag
    always_ff @(posedge clock) begin
        if (rst || power_up) begin
            pd_flag_reg <= 1'b0;
            to_reg <= 1'b0;
        end else begin
            if (enter) begin
                pd_flag_reg <= 1'b1;
            end else if (wdt_clear_exec) begin
                pd_flag_reg <= 1'b0;
            end
            // overflow set wins over a clear in the same cycle
            if (wdt_ovf) begin
                to_reg <= 1'b1;
            end else if (enter || wdt_clear_exec) begin
                to_reg <= 1'b0;
            end
        end
    end

    // axi4-lite slave: accept address and data in any order
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire wr_ctrl = wr_go && aw_addr_reg == PDWD_OFF_WDT_CTRL && w_strb_reg[0];
    wire wr_flags = wr_go && aw_addr_reg == PDWD_OFF_RST_FLAGS && w_strb_reg[0];
    wire wr_clk = wr_go && aw_addr_reg == PDWD_OFF_CLK_CTRL && w_strb_reg[0];
    wire wr_wake = wr_go && aw_addr_reg == PDWD_OFF_WAKE_EN && w_strb_reg[0];
    wire wr_ok = aw_addr_reg == PDWD_OFF_WDT_CTRL || aw_addr_reg == PDWD_OFF_RST_FLAGS
        || aw_addr_reg == PDWD_OFF_CLK_CTRL || aw_addr_reg == PDWD_OFF_WAKE_EN;
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_arready = !s_axi_rvalid;

    // capture write channels and issue response
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PDWD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? PDWD_RESP_OKAY : PDWD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software registers; power-up and external reset restore power-on values
    always_ff @(posedge clock) begin
        if (rst || power_up || ext_reset) begin
            wdt_ctrl_reg <= PDWD_WDT_CTRL_RST;
            clk_ctrl_reg <= PDWD_CLK_CTRL_RST;
            wake_en_reg <= PORT_W'(PDWD_WAKE_EN_RST);
        end else begin
            if (wr_ctrl) begin
                wdt_ctrl_reg <= w_data_reg[7:0];
            end else if (sreset_fire) begin
                wdt_ctrl_reg <= PDWD_WDT_CTRL_RST;
            end
            if (wr_clk) begin
                clk_ctrl_reg <= {6'h00, w_data_reg[1:0]};
            end
            if (wr_wake) begin
                wake_en_reg <= w_data_reg[PORT_W-1:0];
            end
        end
    end

    // reset cause flags; hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            wd_rst_flag_reg <= 1'b0;
            ctl_rst_flag_reg <= 1'b0;
            lv_rst_flag_reg <= 1'b0;
        end else begin
            if (sreset_fire) begin
                wd_rst_flag_reg <= 1'b1;
            end else if (wr_flags && !w_data_reg[PDWD_RF_WDT]) begin
                wd_rst_flag_reg <= 1'b0;
            end
            if (lvr_event) begin
                lv_rst_flag_reg <= 1'b1;
            end else if (wr_flags) begin
                lv_rst_flag_reg <= w_data_reg[PDWD_RF_LVR];
            end
            if (wr_flags) begin
                ctl_rst_flag_reg <= w_data_reg[PDWD_RF_RCTL] & ctl_rst_flag_reg;
            end
        end
    end

    // read mux
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            PDWD_OFF_WDT_CTRL: rd_val[7:0] = wdt_ctrl_reg;
            PDWD_OFF_RST_FLAGS: rd_val[7:0] = {4'h0, ctl_rst_flag_reg, lv_rst_flag_reg, 1'b0,
                wd_rst_flag_reg};
            PDWD_OFF_CLK_CTRL: rd_val[7:0] = clk_ctrl_reg;
            PDWD_OFF_WAKE_EN: rd_val[PORT_W-1:0] = wake_en_reg;
            PDWD_OFF_STATUS: rd_val[5:0] = {mode_reg, to_reg, pd_flag_reg, sreset_pend_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // read response
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PDWD_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? PDWD_RESP_OKAY : PDWD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // registered wake / reset outputs to the core
    always_ff @(posedge clock) begin
        if (rst) begin
            wake_pulse <= 1'b0;
            resume_next <= 1'b0;
            take_interrupt <= 1'b0;
            pc_sp_reset <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            wake_pulse <= any_wake && !full_reset;
            // a serviced interrupt takes the vector even when a port edge wakes too
            resume_next <= !full_reset && (port_wake || irq_wake) && !(irq_wake && int_serv);
            take_interrupt <= !full_reset && irq_wake && int_serv;
            pc_sp_reset <= !full_reset && asleep && wdt_ovf;
            device_reset <= full_reset;
        end
    end

    // clock gating view of the mode
    assign cpu_stopped = asleep;
    assign high_clock_on = !(mode_reg == PDWD_SLEEP || mode_reg == PDWD_IDLE_ZERO);
    assign sub_clock_on = !(mode_reg == PDWD_SLEEP || mode_reg == PDWD_IDLE_TWO);
    assign rc_clock_on = sub_clock_on || wdt_enabled;
    assign power_down_status_flag = pd_flag_reg;
    assign watchdog_timeout_flag = to_reg;

endmodule // pdwd_power_down_watchdog

// >>> pdwd_checker.sv
// checker: timing relations on the power-down watchdog ports
module pdwd_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // core side events
    input wire logic halt_exec,
    input wire logic wdt_clear_exec,
    input wire logic ext_reset,
    input wire logic power_up,
    // core side results
    input wire logic cpu_stopped,
    input wire logic wake_pulse,
    input wire logic resume_next,
    input wire logic take_interrupt,
    input wire logic pc_sp_reset,
    input wire logic device_reset,
    input wire logic power_down_status_flag,
    input wire logic watchdog_timeout_flag
);
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // a clean halt, with no competing event, stops the program next cycle
    property p_halt_stops;
        halt_exec && !cpu_stopped && !ext_reset && !power_up && !wdt_clear_exec |=> cpu_stopped;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop cpu");
    property p_halt_flags;
        halt_exec && !cpu_stopped && !ext_reset && !power_up && !wdt_clear_exec
            |=> power_down_status_flag && !watchdog_timeout_flag;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("entry flags wrong");
    property p_clr_pwrdn;
        wdt_clear_exec && !halt_exec |=> !power_down_status_flag;
    endproperty
    a_clr_pwrdn: assert property (p_clr_pwrdn) else $error("clear kept power-down flag");
    property p_pu_flags;
        power_up && !halt_exec |=> !power_down_status_flag && !watchdog_timeout_flag;
    endproperty
    a_pu_flags: assert property (p_pu_flags) else $error("power up kept flags");
    property p_ext_rst;
        ext_reset |=> device_reset;
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("no reset after ext reset");
    // a wake only ever ends a stopped period
    property p_wake_src;
        wake_pulse |-> $past(cpu_stopped) && !cpu_stopped;
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake without stop");
    property p_resume_excl;
        resume_next || take_interrupt |-> wake_pulse && !(resume_next && take_interrupt);
    endproperty
    a_resume_excl: assert property (p_resume_excl) else $error("bad resume");
    property p_wdt_wake;
        pc_sp_reset |-> watchdog_timeout_flag && power_down_status_flag;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("overflow flags wrong");
    // main scenarios reached
    c_halt: cover property (halt_exec && !cpu_stopped);
    c_irq: cover property (take_interrupt);
    c_wdt: cover property (pc_sp_reset);
endmodule // pdwd_checker

bind pdwd_power_down_watchdog pdwd_checker u_chk (.clock, .rst, .halt_exec, .wdt_clear_exec,
    .ext_reset, .power_up, .cpu_stopped, .wake_pulse, .resume_next, .take_interrupt,
    .pc_sp_reset, .device_reset, .power_down_status_flag, .watchdog_timeout_flag);

// >>> power_down_wakeup_watchdog_tb_top.sv
// testbench: bus, power-down, wake-up and watchdog scenarios
module power_down_wakeup_watchdog_tb_top import pdwd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // design inputs, all defined at time zero
    logic clock = 1'b0, rst = 1'b1, halt_exec = 1'b0, wdt_clear_exec = 1'b0;
    logic ext_reset = 1'b0, power_up = 1'b0, lvr_event = 1'b0, stack_full = 1'b0;
    logic [7:0] int_req = 8'h00, int_enable = 8'h00, port_a_in = 8'hFF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    // design outputs
    logic cpu_stopped, high_clock_on, sub_clock_on, rc_clock_on, wake_pulse, resume_next;
    logic take_interrupt, pc_sp_reset, device_reset, power_down_status_flag;
    logic watchdog_timeout_flag, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // expected bus answers, oldest first
    logic [34:0] rq[$];
    logic [1:0] bq[$];
    logic [34:0] e;
    logic [15:0] lfsr = 16'h109B;
    logic [2:0] mode_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    int err_count = 0, num_checks = 0, resets = 0, i, n, r0;
    always #2.5 clock = ~clock;
    // short counts so the watchdog and the delay fit the run
    pdwd_power_down_watchdog #(.SRESET_CYCLES(4), .RC_DIVIDE(2)) uut (.*);
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic give_up(string nm);
        err_count++;
        $display("MISMATCH %s expected event seen timeout", nm);
        end_of_test();
    endtask
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic tick(int k);
        repeat (k) @(posedge clock);
    endtask
    // ready is sampled at the falling edge, where it already shows its rising-edge value
    task automatic axw(logic [7:0] a, logic [7:0] d, logic [1:0] r);
        logic ah, wh, bh;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(negedge clock);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            @(posedge clock);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            // bready stays up, so a following write never assigns it twice in one step
            if (bh) return;
        end
        give_up("write");
    endtask
    task automatic axr(logic [7:0] a, logic [7:0] d, logic [1:0] r, logic cd);
        logic ah, rh;
        rq.push_back({cd, r, 24'h000000, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(negedge clock);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            @(posedge clock);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) return;
        end
        give_up("read");
    endtask
    // bounded wait for a pulse: 0 wake, 1 device reset, 2 pc/sp reset
    task automatic wait_for(int sel, int lim, output int c);
        for (c = 0; c < lim; c++) begin
            @(negedge clock);
            if ((sel == 0 ? wake_pulse : sel == 1 ? device_reset : pc_sp_reset) === 1'b1) return;
        end
        give_up("event");
    endtask
    task automatic halt();
        halt_exec <= 1'b1;
        tick(1);
        halt_exec <= 1'b0;
    endtask
    // watcher: compares each bus answer with the oldest note
    always @(negedge clock) begin
        if (device_reset === 1'b1) resets++;
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0) chk("bresp", s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
            e = rq.pop_front();
            chk("rresp", s_axi_rresp, e[33:32]);
            if (e[34]) chk("rdata", s_axi_rdata, e[31:0]);
        end
    end
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(1);
        axr(PDWD_OFF_WDT_CTRL, PDWD_WDT_CTRL_RST, PDWD_RESP_OKAY, 1'b1);
        axr(PDWD_OFF_CLK_CTRL, PDWD_CLK_CTRL_RST, PDWD_RESP_OKAY, 1'b1);
        axr(8'h14, 8'h00, PDWD_RESP_SLVERR, 1'b0);
        axw(8'h14, 8'h00, PDWD_RESP_SLVERR);
        for (i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            axw(PDWD_OFF_WAKE_EN, lfsr[7:0], PDWD_RESP_OKAY);
            axr(PDWD_OFF_WAKE_EN, lfsr[7:0], PDWD_RESP_OKAY, 1'b1);
        end
        $display("test registers done");
        axw(PDWD_OFF_WAKE_EN, 8'h01, PDWD_RESP_OKAY);
        int_req <= 8'h02;
        for (i = 0; i < 4; i++) begin
            axw(PDWD_OFF_CLK_CTRL, {6'h00, i[1:0]}, PDWD_RESP_OKAY);
            halt();
            tick(1);
            chk("stopped", cpu_stopped, 1'b1);
            chk("high clock", high_clock_on, i[1]);
            chk("sub clock", sub_clock_on, i[0]);
            chk("rc clock", rc_clock_on, 1'b1);
            axr(PDWD_OFF_STATUS, {2'b00, mode_tab[i], 3'b010}, PDWD_RESP_OKAY, 1'b1);
            chk("pending flag wake", cpu_stopped, 1'b1);
            lfsr = lfsr_next(lfsr);
            port_a_in <= {lfsr[7:1], 1'b0};
            wait_for(0, 20, n);
            chk("port resume", resume_next, 1'b1);
            tick(1);
            port_a_in <= 8'hFF;
        end
        wdt_clear_exec <= 1'b1;
        tick(1);
        wdt_clear_exec <= 1'b0;
        tick(1);
        chk("power-down flag after clear", power_down_status_flag, 1'b0);
        $display("test modes done");
        axw(PDWD_OFF_CLK_CTRL, 8'h00, PDWD_RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            int_enable <= (i == 1) ? 8'h00 : 8'h04;
            stack_full <= (i == 2);
            halt();
            tick(2);
            int_req <= 8'h06;
            wait_for(0, 20, n);
            chk("take int", take_interrupt, i == 0);
            chk("resume int", resume_next, i != 0);
            tick(1);
            int_req <= 8'h02;
            tick(2);
        end
        int_req <= 8'h00;
        $display("test interrupts done");
        // select codes 0 and 1: 2^8 and 2^10 rc ticks of two clocks each
        for (i = 0; i < 2; i++) begin
            axw(PDWD_OFF_WDT_CTRL, {PDWD_KEY_ENABLE, i[2:0]}, PDWD_RESP_OKAY);
            wdt_clear_exec <= 1'b1;
            tick(1);
            wdt_clear_exec <= 1'b0;
            wait_for(1, 3000, n);
            chk("run period", n >= (500 << 2 * i) && n <= (530 << 2 * i), 1'b1);
            chk("run timeout", watchdog_timeout_flag, 1'b1);
            tick(1);
        end
        r0 = resets;
        repeat (6) begin
            tick(300);
            wdt_clear_exec <= 1'b1;
            tick(1);
            wdt_clear_exec <= 1'b0;
        end
        chk("cleared no reset", resets, r0);
        axw(PDWD_OFF_WDT_CTRL, {PDWD_KEY_ENABLE, 3'b000}, PDWD_RESP_OKAY);
        halt();
        wait_for(2, 2000, n);
        chk("sleep period", n >= 500 && n <= 530, 1'b1);
        chk("sleep timeout", watchdog_timeout_flag, 1'b1);
        tick(1);
        axw(PDWD_OFF_WDT_CTRL, {PDWD_KEY_DISABLE, 3'b000}, PDWD_RESP_OKAY);
        r0 = resets;
        halt();
        tick(1500);
        chk("disabled asleep", cpu_stopped, 1'b1);
        chk("rc clock off", rc_clock_on, 1'b0);
        chk("disabled no reset", resets, r0);
        ext_reset <= 1'b1;
        tick(1);
        ext_reset <= 1'b0;
        wait_for(1, 10, n);
        chk("ext reset", n, 0);
        tick(2);
        $display("test watchdog done");
        axw(PDWD_OFF_RST_FLAGS, 8'h00, PDWD_RESP_OKAY);
        axw(PDWD_OFF_WDT_CTRL, 8'h00, PDWD_RESP_OKAY);
        wait_for(1, 50, n);
        chk("key delay", n >= 3 && n <= 8, 1'b1);
        tick(2);
        axr(PDWD_OFF_RST_FLAGS, 8'h01, PDWD_RESP_OKAY, 1'b1);
        axr(PDWD_OFF_WDT_CTRL, PDWD_WDT_CTRL_RST, PDWD_RESP_OKAY, 1'b1);
        axw(PDWD_OFF_RST_FLAGS, 8'h01, PDWD_RESP_OKAY);
        axr(PDWD_OFF_RST_FLAGS, 8'h01, PDWD_RESP_OKAY, 1'b1);
        axw(PDWD_OFF_RST_FLAGS, 8'h00, PDWD_RESP_OKAY);
        lvr_event <= 1'b1;
        tick(1);
        lvr_event <= 1'b0;
        axr(PDWD_OFF_RST_FLAGS, 8'h04, PDWD_RESP_OKAY, 1'b1);
        halt();
        tick(2);
        power_up <= 1'b1;
        tick(1);
        power_up <= 1'b0;
        tick(1);
        chk("power-down flag power up", power_down_status_flag, 1'b0);
        $display("test reset flags done");
        end_of_test();
    end
endmodule // power_down_wakeup_watchdog_tb_top
